// file: rtl/exec_pkg.sv
// shared constants, types and helper functions of the and/add/zero-branch execute block
package exec_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int unsigned WORD_W = 32;
  localparam int unsigned IMM_W  = 16;
  localparam int unsigned OPC_W  = 6;
  localparam int unsigned REG_W  = 5;
  localparam int unsigned COND_W = 4;

  // ------------------------------------------------------------
  // field positions, lsb of each field in the instruction word
  // ------------------------------------------------------------
  localparam int unsigned OPC_LSB    = 26;
  localparam int unsigned RD_LSB     = 21;
  localparam int unsigned SRC1_LSB   = 16;
  localparam int unsigned SRC2_LSB   = 11;
  localparam int unsigned IMM_LSB    = 0;
  localparam int unsigned COND_LSB   = 21;
  localparam int unsigned D_BIT      = 25;

  // bit positions inside the opcode field
  localparam int unsigned OPC_IMM_BIT = 3;
  localparam int unsigned OPC_K_BIT   = 2;
  localparam int unsigned OPC_C_BIT   = 1;
  localparam int unsigned OPC_INV_BIT = 1;

  // ------------------------------------------------------------
  // opcode classes: (opcode & mask) == value
  // ------------------------------------------------------------
  localparam logic [5:0] ADD_MASK    = 6'h31;
  localparam logic [5:0] ADD_VALUE   = 6'h00;
  localparam logic [5:0] AND_MASK    = 6'h35;
  localparam logic [5:0] AND_VALUE   = 6'h21;
  localparam logic [5:0] BCC_MASK    = 6'h37;
  localparam logic [5:0] BCC_VALUE   = 6'h27;
  localparam logic [5:0] PREFIX_OPC  = 6'h2c;

  // branch condition codes
  localparam logic [3:0] COND_EQ = 4'h0;
  localparam logic [3:0] COND_GE = 4'h5;

  // ------------------------------------------------------------
  // reset values and steps
  // ------------------------------------------------------------
  localparam logic [31:0] PC_RESET    = 32'h0000_0000;
  localparam logic [31:0] PC_STEP     = 32'h0000_0004;
  localparam logic        CARRY_RESET = 1'b0;

  // ------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    st_run,
    st_gap_slot,
    st_slot,
    st_gap1,
    st_gap2
  } exec_state_t;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] sext_imm(input logic [15:0] imm);
    sext_imm = {{16{imm[15]}}, imm};
  endfunction

  function automatic logic opc_match(input logic [5:0] opc,
                                     input logic [5:0] mask,
                                     input logic [5:0] value);
    opc_match = ((opc & mask) == value);
  endfunction

  function automatic logic cond_known(input logic [3:0] cond);
    cond_known = (cond == COND_EQ) || (cond == COND_GE);
  endfunction

  function automatic logic cond_true(input logic [3:0] cond, input logic [31:0] a);
    cond_true = 1'b0;
    if (cond == COND_EQ) begin
      cond_true = (a == 32'h0000_0000);
    end else if (cond == COND_GE) begin
      cond_true = !a[31];
    end
  endfunction

endpackage

// file: rtl/logic_add_unit.sv
// combinational datapath for the add and and/and-not families
`timescale 1ns/10ps
`default_nettype none
module logic_add_unit (
  input  wire logic [5:0]  opcode,
  input  wire logic [31:0] first_source_value,
  input  wire logic [31:0] second_source_value,
  input  wire logic [31:0] imm_operand,
  input  wire logic        status_carry_flag,
  output logic [31:0]      result,
  output logic             carry_out,
  output logic             carry_update,
  output logic             writes_dest
);

  // ------------------------------------------------------------
  // operand select and arithmetic
  // ------------------------------------------------------------
  logic        is_add;
  logic        is_and;
  logic [31:0] operand_b;
  logic [32:0] sum;
  logic        carry_in;

  always_comb begin
    is_add    = exec_pkg::opc_match(opcode, exec_pkg::ADD_MASK, exec_pkg::ADD_VALUE);
    is_and    = exec_pkg::opc_match(opcode, exec_pkg::AND_MASK, exec_pkg::AND_VALUE);
    operand_b = opcode[exec_pkg::OPC_IMM_BIT] ? imm_operand : second_source_value;
    // the opcode c bit only selects; the value added is the status flag
    carry_in  = opcode[exec_pkg::OPC_C_BIT] & status_carry_flag;
    sum       = {1'b0, first_source_value} + {1'b0, operand_b} + {32'h0000_0000, carry_in};
    result    = 32'h0000_0000;
    carry_out = sum[32];
    carry_update = 1'b0;
    writes_dest  = 1'b0;
    if (is_add) begin
      result       = sum[31:0];
      carry_update = !opcode[exec_pkg::OPC_K_BIT];
      writes_dest  = 1'b1;
    end else if (is_and) begin
      // the inverting bit shares its slot with the add c bit
      if (opcode[exec_pkg::OPC_INV_BIT]) begin
        result = first_source_value & ~operand_b;
      end else begin
        result = first_source_value & operand_b;
      end
      writes_dest = 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: rtl/zero_branch_exec.sv
// execute stage for add, and, and-not and compare-with-zero branches
// ------------------------------------------------------------
// Notes on behaviour
// - c bit adds status carry into sum
// - k bit keeps carry, else load carry-out
// - opcode c bit distinct from status carry
// - immediate sign-extended from 16 to 32
// - preceding prefix supplies upper immediate half
// - and writes first and second source
// - and-immediate uses sign-extended immediate
// - and-not inverts second source first
// - and-not-immediate inverts extended immediate
// - equal branch taken when source is zero
// - greater-equal branch taken when source non-negative
// - register branch target pc plus second source
// - immediate branch target pc plus immediate
// - delay bit lets next instruction complete
// - no delay bit squashes sequential instruction
// - branch takes one, two or three cycles
// - fields: opcode, dest, source, immediate positions
// ------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module zero_branch_exec (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr_word,
  input  wire logic [31:0] first_source_value,
  input  wire logic [31:0] second_source_value,
  output logic             instr_ready,
  output logic             rf_write_en,
  output logic [4:0]       rf_write_addr,
  output logic [31:0]      rf_write_data,
  output logic             status_carry_flag,
  output logic [31:0]      pc,
  output logic             fetch_redirect,
  output logic [31:0]      fetch_target,
  output logic             unsupported
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  exec_pkg::exec_state_t state_reg;
  exec_pkg::exec_state_t state_next;
  logic        ready_reg;
  logic        we_reg;
  logic [4:0]  waddr_reg;
  logic [31:0] wdata_reg;
  logic        carry_reg;
  logic [31:0] pc_reg;
  logic        redirect_reg;
  logic [31:0] target_reg;
  logic        unsupported_reg;
  logic        prefix_valid_reg;
  logic [15:0] prefix_hi_reg;
  logic [31:0] pending_target_reg;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  logic [5:0]  opcode;
  logic [4:0]  dest_field;
  logic [15:0] imm_field;
  logic [3:0]  cond_field;
  logic        delay_bit;
  logic        is_prefix;
  logic        is_branch;
  logic        accept;
  logic        in_slot;
  logic        taken;
  logic [31:0] imm_operand;
  logic [31:0] branch_target;
  logic [31:0] alu_result;
  logic        alu_carry;
  logic        alu_carry_update;
  logic        alu_writes;

  assign opcode     = instr_word[exec_pkg::OPC_LSB +: exec_pkg::OPC_W];
  assign dest_field = instr_word[exec_pkg::RD_LSB +: exec_pkg::REG_W];
  assign imm_field  = instr_word[exec_pkg::IMM_LSB +: exec_pkg::IMM_W];
  assign cond_field = instr_word[exec_pkg::COND_LSB +: exec_pkg::COND_W];
  assign delay_bit  = instr_word[exec_pkg::D_BIT];
  assign is_prefix  = (opcode == exec_pkg::PREFIX_OPC);
  assign is_branch  = exec_pkg::opc_match(opcode, exec_pkg::BCC_MASK, exec_pkg::BCC_VALUE);
  assign accept     = instr_valid && ready_reg;
  assign in_slot    = (state_reg == exec_pkg::st_slot);

  // prefix only covers the one instruction right after it
  assign imm_operand = prefix_valid_reg ? {prefix_hi_reg, imm_field}
                                        : exec_pkg::sext_imm(imm_field);

  // a branch sitting in a delay slot is not evaluated
  assign taken = is_branch && !in_slot
               && exec_pkg::cond_true(cond_field, first_source_value);

  assign branch_target = opcode[exec_pkg::OPC_IMM_BIT] ? pc_reg + imm_operand
                                                       : pc_reg + second_source_value;

  logic_add_unit u_alu (
    .opcode              (opcode),
    .first_source_value  (first_source_value),
    .second_source_value (second_source_value),
    .imm_operand         (imm_operand),
    .status_carry_flag   (carry_reg),
    .result              (alu_result),
    .carry_out           (alu_carry),
    .carry_update        (alu_carry_update),
    .writes_dest         (alu_writes)
  );

  // ------------------------------------------------------------
  // sequencer: extra stall cycles after a taken branch
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      exec_pkg::st_run: begin
        if (accept && taken) begin
          state_next = delay_bit ? exec_pkg::st_gap_slot
                                 : exec_pkg::st_gap1;
        end
      end
      exec_pkg::st_gap_slot: state_next = exec_pkg::st_slot;
      exec_pkg::st_slot: begin
        if (accept) begin
          state_next = exec_pkg::st_run;
        end
      end
      exec_pkg::st_gap1: state_next = exec_pkg::st_gap2;
      exec_pkg::st_gap2: state_next = exec_pkg::st_run;
      default: state_next = exec_pkg::st_run;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= exec_pkg::st_run;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      // input is ignored while stalled, which drops the fall-through fetch
      ready_reg <= (state_next == exec_pkg::st_run) || (state_next == exec_pkg::st_slot);
    end
  end

  // ------------------------------------------------------------
  // immediate prefix
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prefix_valid_reg <= 1'b0;
      prefix_hi_reg    <= 16'h0000;
    end else if (accept) begin
      prefix_valid_reg <= is_prefix;
      if (is_prefix) begin
        prefix_hi_reg <= imm_field;
      end
    end
  end

  // ------------------------------------------------------------
  // write-back and carry
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      we_reg    <= 1'b0;
      waddr_reg <= 5'h00;
      wdata_reg <= 32'h0000_0000;
    end else begin
      we_reg <= accept && alu_writes;
      if (accept && alu_writes) begin
        waddr_reg <= dest_field;
        wdata_reg <= alu_result;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      carry_reg <= exec_pkg::CARRY_RESET;
    end else if (accept && alu_carry_update) begin
      carry_reg <= alu_carry;
    end
  end

  // ------------------------------------------------------------
  // program counter and fetch redirect
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pc_reg             <= exec_pkg::PC_RESET;
      pending_target_reg <= exec_pkg::PC_RESET;
      redirect_reg       <= 1'b0;
      target_reg         <= exec_pkg::PC_RESET;
    end else begin
      redirect_reg <= 1'b0;
      if (accept && in_slot) begin
        pc_reg       <= pending_target_reg;
        redirect_reg <= 1'b1;
        target_reg   <= pending_target_reg;
      end else if (accept && taken && !delay_bit) begin
        pc_reg       <= branch_target;
        redirect_reg <= 1'b1;
        target_reg   <= branch_target;
      end else if (accept && taken) begin
        pc_reg             <= pc_reg + exec_pkg::PC_STEP;
        pending_target_reg <= branch_target;
      end else if (accept) begin
        pc_reg <= pc_reg + exec_pkg::PC_STEP;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      unsupported_reg <= 1'b0;
    end else begin
      unsupported_reg <= accept && !alu_writes && !is_prefix
                         && !(is_branch && exec_pkg::cond_known(cond_field));
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign instr_ready       = ready_reg;
  assign rf_write_en       = we_reg;
  assign rf_write_addr     = waddr_reg;
  assign rf_write_data     = wdata_reg;
  assign status_carry_flag = carry_reg;
  assign pc                = pc_reg;
  assign fetch_redirect    = redirect_reg;
  assign fetch_target      = target_reg;
  assign unsupported       = unsupported_reg;

endmodule
`default_nettype wire

// file: testbench/zero_branch_exec_assertions.sv
// concurrent checks on the ports of the execute block
`timescale 1ns/10ps
`default_nettype none
module zero_branch_exec_checker (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] first_source_value,
  input wire logic [31:0] second_source_value,
  input wire logic        instr_ready,
  input wire logic        rf_write_en,
  input wire logic [4:0]  rf_write_addr,
  input wire logic [31:0] rf_write_data,
  input wire logic        status_carry_flag,
  input wire logic [31:0] pc,
  input wire logic        fetch_redirect,
  input wire logic [31:0] fetch_target,
  input wire logic        unsupported
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  logic             pre_reg;
  wire logic        acc = instr_valid && instr_ready;
  wire logic [5:0]  op  = instr_word[31:26];
  wire logic [3:0]  cd  = instr_word[24:21];
  wire logic [31:0] fa  = first_source_value;
  wire logic [31:0] sb  = second_source_value;
  wire logic [31:0] sx  = {{16{instr_word[15]}}, instr_word[15:0]};
  wire logic        br  = acc && ((op & 6'h37) == 6'h27);
  // a prefix widens the next immediate, so sign-extension checks skip that case
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pre_reg <= 1'b0;
    end else if (acc) begin
      pre_reg <= (op == 6'h2c);
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_and_reg: assert property (acc && op == 6'h21 |=>
    rf_write_en && rf_write_data == ($past(fa) & $past(sb))) else $error("and result wrong");
  a_andn_reg: assert property (acc && op == 6'h23 |=>
    rf_write_data == ($past(fa) & ~$past(sb))) else $error("and-not result wrong");
  a_andi_sext: assert property (acc && op == 6'h29 && !pre_reg |=>
    rf_write_data == ($past(fa) & $past(sx))) else $error("and-imm result wrong");
  a_andni_sext: assert property (acc && op == 6'h2b && !pre_reg |=>
    rf_write_data == ($past(fa) & ~$past(sx))) else $error("and-not-imm result wrong");
  a_add_plain: assert property (acc && op == 6'h00 |=>
    {status_carry_flag, rf_write_data} == {1'b0, $past(fa)} + {1'b0, $past(sb)})
    else $error("plain add wrong");
  a_addic_carry: assert property (acc && op == 6'h0a && !pre_reg |=>
    {status_carry_flag, rf_write_data} == {1'b0, $past(fa)} + {1'b0, $past(sx)}
    + {32'h0, $past(status_carry_flag)}) else $error("add with carry wrong");
  a_keep_carry: assert property (acc && ((op & 6'h35) == 6'h04 ||
    (op & 6'h35) == 6'h21) |=> $stable(status_carry_flag)) else $error("carry not kept");
  a_dest_addr: assert property (acc && (op & 6'h31) == 6'h00 |=>
    rf_write_en && rf_write_addr == $past(instr_word[25:21])) else $error("dest wrong");
  a_eq_fall: assert property (br && cd == 4'h0 && fa != 32'h0 && $past(instr_ready) |=>
    pc == $past(pc) + 32'h4 && !fetch_redirect && !rf_write_en) else $error("eq fell wrong");
  a_ge_gap: assert property (br && cd == 4'h5 && !fa[31] && !instr_word[25]
    && $past(instr_ready) |=> fetch_redirect && !instr_ready ##1 !instr_ready
    && !fetch_redirect ##1 instr_ready) else $error("taken branch timing wrong");
  a_eq_target: assert property (br && !op[3] && cd == 4'h0 && fa == 32'h0
    && !instr_word[25] && $past(instr_ready) |=> pc == $past(pc) + $past(sb)
    && fetch_target == pc) else $error("branch target wrong");
  a_delay_slot: assert property (br && op[3] && instr_word[25] && cd == 4'h0
    && fa == 32'h0 && $past(instr_ready) |=> pc == $past(pc) + 32'h4 && !fetch_redirect
    && !instr_ready ##1 instr_ready) else $error("delayed branch wrong");
endmodule
bind zero_branch_exec zero_branch_exec_checker i_chk (.sys_clk, .rst_n, .instr_valid,
  .instr_word, .first_source_value, .second_source_value, .instr_ready, .rf_write_en,
  .rf_write_addr, .rf_write_data, .status_carry_flag, .pc, .fetch_redirect, .fetch_target,
  .unsupported);
`default_nettype wire

// file: testbench/tb.sv
// self-checking random bench for the execute block
`timescale 1ns/10ps
`default_nettype none
`define CMP(nm, e, s) begin n_tests++; if ((s) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module tb;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        instr_valid = 1'b0;
  logic [31:0] instr_word = 32'h0;
  logic [31:0] first_source_value = 32'h0;
  logic [31:0] second_source_value = 32'h0;
  wire logic   instr_ready, rf_write_en, status_carry_flag, fetch_redirect, unsupported;
  wire logic [4:0]  rf_write_addr;
  wire logic [31:0] rf_write_data, pc, fetch_target;
  logic [31:0] e_pc, p_tgt;
  logic [15:0] x_imm;
  logic        e_c, p_v, x_v;
  int          errors, n_tests, seed, i, p;
  zero_branch_exec i_zero_branch_exec (.sys_clk, .rst_n, .instr_valid, .instr_word,
    .first_source_value, .second_source_value, .instr_ready, .rf_write_en, .rf_write_addr,
    .rf_write_data, .status_carry_flag, .pc, .fetch_redirect, .fetch_target, .unsupported);
  always #50 sys_clk = ~sys_clk;
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    instr_valid = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    `CMP("rst_pc", 32'h0, pc)
    `CMP("rst_carry", 1'b0, status_carry_flag)
    `CMP("rst_ready", 1'b0, instr_ready)
    `CMP("rst_we", 1'b0, rf_write_en)
    rst_n = 1'b1;
    e_pc = 32'h0; e_c = 1'b0; p_v = 1'b0; x_v = 1'b0;
  endtask
  // one accepted instruction, predicted from the instruction semantics
  task automatic exec(input logic [31:0] w, input logic [31:0] a, input logic [31:0] b);
    logic [5:0]  op;
    logic [31:0] im, o2, npc, res;
    logic [32:0] sum;
    logic        we, red, uns, tk, nc, slot;
    int          lat, n;
    op = w[31:26];
    im = x_v ? {x_imm, w[15:0]} : {{16{w[15]}}, w[15:0]};
    o2 = op[3] ? im : b;
    we = 1'b0; red = 1'b0; uns = 1'b0; tk = 1'b0; lat = 1; nc = e_c; res = 32'h0; slot = p_v;
    npc = e_pc + 32'h4;
    p_v = 1'b0;
    if ((op & 6'h31) == 6'h00) begin
      sum = {1'b0, a} + {1'b0, o2} + {32'h0, op[1] & e_c};
      we = 1'b1; res = sum[31:0];
      if (!op[2]) nc = sum[32];
    end else if ((op & 6'h35) == 6'h21) begin
      we = 1'b1; res = a & (op[1] ? ~o2 : o2);
    end else if ((op & 6'h37) == 6'h27) begin
      if (w[24:21] == 4'h0) tk = (a == 32'h0);
      else if (w[24:21] == 4'h5) tk = !a[31];
      else uns = 1'b1;
      if (tk && w[25]) begin
        lat = 2; p_v = 1'b1; p_tgt = e_pc + o2;
      end else if (tk) begin
        lat = 3; red = 1'b1; npc = e_pc + o2;
      end
    end
    if (slot) begin
      red = 1'b1; npc = p_tgt;
    end
    x_v = (op == 6'h2c);
    x_imm = w[15:0];
    instr_valid = 1'b1; instr_word = w;
    first_source_value = a; second_source_value = b;
    n = 0;
    while (instr_ready !== 1'b1 && n < 20) begin
      @(posedge sys_clk); #1; n++;
    end
    if (instr_ready !== 1'b1) begin
      errors++; finish_test();
    end
    @(posedge sys_clk); #1;
    // the stray word only goes out while stalled, so no step drives the word twice
    if (instr_ready !== 1'b1) instr_word = {6'h00, w[25:0]};
    `CMP("write_en", we, rf_write_en)
    if (we) `CMP("addr", w[25:21], rf_write_addr)
    if (we) `CMP("data", res, rf_write_data)
    `CMP("carry", nc, status_carry_flag)
    `CMP("pc", npc, pc)
    `CMP("redirect", red, fetch_redirect)
    if (red) `CMP("target", npc, fetch_target)
    `CMP("unsupported", uns, unsupported)
    n = 1;
    // a stray add offered while stalled must be dropped
    while (instr_ready !== 1'b1 && n < 8) begin
      @(posedge sys_clk); #1; n++;
      `CMP("squash", 1'b0, rf_write_en)
    end
    // valid stays up; the next call or a reset replaces it in this same step
    `CMP("latency", lat, n)
    if (instr_ready !== 1'b1) begin
      errors++;
      finish_test();
    end
    e_pc = npc; e_c = nc;
  endtask
  task automatic rand_op();
    logic [31:0] w, a, b;
    int          k;
    k = $unsigned($random(seed)) % 10;
    if (p_v && k > 5) k = k - 6;
    w = $random(seed);
    a = $random(seed);
    b = $random(seed);
    // zero and the sign bit alone are the compare boundaries
    if (a[3:2] == 2'b00) a = 32'h0;
    else if (a[3:2] == 2'b01) a = {a[31], 31'h0};
    case (k)
      0, 1, 2, 3: w[31:26] = {2'b00, w[3:1], 1'b0};
      4, 5: w[31:26] = {2'b10, w[3], 1'b0, w[1], 1'b1};
      6, 7, 8: begin
        w[31:26] = {2'b10, w[3], 3'b111};
        w[24:21] = w[5] ? 4'h5 : (w[7:6] == 2'b00 ? 4'h3 : 4'h0);
      end
      default: w[31:26] = 6'h2c;
    endcase
    exec(w, a, b);
  endtask
  // ------------------------------------------------------------
  // main sequence, run twice to cover a reset in mid-run
  // ------------------------------------------------------------
  initial begin
    seed = 85; errors = 0; n_tests = 0;
    for (p = 0; p < 2; p++) begin
      do_reset();
      exec({6'h00, 10'h0, 16'h0}, 32'hffff_ffff, 32'h1);
      exec({6'h0e, 10'h1, 16'hffff}, 32'h1, 32'h0);
      exec({6'h2c, 10'h0, 16'h8000}, 32'h0, 32'h0);
      exec({6'h29, 10'h21, 16'h0001}, 32'hffff_ffff, 32'h0);
      exec({6'h2f, 1'b1, 4'h0, 5'h0, 16'h0010}, 32'h0, 32'h0);
      exec({6'h23, 10'h3ff, 16'h0}, 32'hffff_ffff, 32'h00ff_00ff);
      for (i = 0; i < 300; i++) rand_op();
      $display("run %0d done, mismatches %0d", p, errors);
    end
    finish_test();
  end
endmodule
`undef CMP
`default_nettype wire
